// *** core/wdb_consts.svh ***
`ifndef WDB_CONSTS_SVH
`define WDB_CONSTS_SVH
// ------------------------------------------------------------
// register indices and byte addresses
// ------------------------------------------------------------
`define WDB_WDC_IDX      8'hE1
`define WDB_PGC_IDX      8'hE7
`define WDB_WDC_ADDR     {4'h0, `WDB_WDC_IDX, 2'h0}
`define WDB_PGC_ADDR     {4'h0, `WDB_PGC_IDX, 2'h0}
// ------------------------------------------------------------
// watchdog_control fields
// ------------------------------------------------------------
`define WDB_FLAG_BIT     7
`define WDB_RUN_BIT      5
`define WDB_RESTART_BIT  4
`define WDB_IDLE_BIT     3
`define WDB_PS_LSB       0
// ------------------------------------------------------------
// programming_control fields
// ------------------------------------------------------------
`define WDB_PGEN_BIT     7
`define WDB_BOOT_BIT     6
`define WDB_SOFTWARE_RESET_TRIGGER_BIT    5
`define WDB_WT_LSB       0
// ------------------------------------------------------------
// reset values, bus codes and counts
// ------------------------------------------------------------
`define WDB_BOOT_RST     1'b1
`define WDB_HTRANS_NSEQ  2'h2
`define WDB_CLK_DIV      12
`define WDB_PRE_W        8
`define WDB_CNT_W        15
`endif

// *** core/wdb_pkg.sv ***
package wdb_pkg;
  // ahb-lite request toward the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } wdb_ahb_req_t;
  // ahb-lite answer from the slave
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } wdb_ahb_rsp_t;
  // cause of the last system reset
  typedef enum logic [1:0] {
    WDB_CAUSE_POWER,
    WDB_CAUSE_WDOG,
    WDB_CAUSE_PIN,
    WDB_CAUSE_SOFT
  } wdb_cause_t;
endpackage

// *** core/wdb_top.sv ***
`timescale 1ns/1ps
`include "wdb_consts.svh"
// What this block does
// - prescaler of 8 bits, then 15-bit counter
// - run bit set starts counting
// - run bit clear halts counting
// - counter overflow raises system reset
// - restart bit recounts, clears by itself
// - idle-run bit gates counting in idle
// - prescale factor is two to code plus one
// - overflow after 12 x prescale x 32768 clocks
// - flag bit 7 marks watchdog reset
// - watchdog reset keeps data ram
// - watchdog, pin, 20H reset boot application
// - 60H write resets into programming monitor
// - power-on starts in programming monitor
// - boot select bit picks software reset target
// - software reset bit resets, self clears
module wdb_top
#(
  parameter int CLK_DIV = `WDB_CLK_DIV, // clocks per prescaler step
  parameter int PRE_W   = `WDB_PRE_W,   // prescaler width
  parameter int CNT_W   = `WDB_CNT_W    // counting stage width
)
(
  input  wire logic                  core_clk_i,      // system clock
  input  wire logic                  reset_n_i,       // power-on reset, async
  input  wire wdb_pkg::wdb_ahb_req_t ahb_i,           // bus request
  input  wire logic                  cpu_idle_i,      // core is in idle mode
  input  wire logic                  pin_reset_i,     // reset pin asserted
  output wdb_pkg::wdb_ahb_rsp_t      ahb_o,           // bus answer
  output logic                       sys_reset_o,     // system reset pulse
  output logic                       boot_monitor_o,  // 1: restart in monitor area
  output logic                       ram_retain_o     // 1: data ram kept (warm)
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // the whole module state is one packed struct
  typedef struct packed {
    logic                 run;        // watchdog_run
    logic                 idle_run;   // watchdog_idle_run
    logic [2:0]           ps;         // prescale select
    logic                 wflag;      // watchdog reset flag
    logic                 pg_en;      // programming enable
    logic                 boot_sel;   // boot_target_select
    logic [2:0]           wt;         // programming wait code
    logic [3:0]           div;        // clock divider stage
    logic [PRE_W-1:0]     pre;        // prescaler stage
    logic [CNT_W-1:0]     cnt;        // counting stage
    logic                 wr_pend;    // write data phase pending
    logic [13:0]          wr_addr;    // latched write address
    logic                 rst;        // system reset pulse
    logic                 boot_mon;   // restart target
    logic                 ram_keep;   // warm reset indicator
    logic                 pin_d;      // reset pin last level
    wdb_pkg::wdb_cause_t  cause;      // last reset cause
    logic [31:0]          rdata;      // read data
  } wdb_state_t;

  // registered state, its next value and the decode helpers
  wdb_state_t        state_ff;        // registered state
  wdb_state_t        nxt_state;       // next state
  logic              addr_take;       // address phase accepted
  logic              wdc_wr;          // write to watchdog_control
  logic              pgc_wr;          // write to programming_control
  logic              counting;        // stages advance this cycle
  logic              div_wrap;        // divider end of period
  logic              pre_tick;        // prescaler period done
  logic              ovf;             // counter overflow
  logic [PRE_W-1:0]  pre_mask;        // prescale period mask
  logic [7:0]        wd;              // written byte

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // one process decides bus, counter and reset behaviour
  always_comb
  begin
    nxt_state = state_ff;
    wd        = ahb_i.hwdata[7:0];
    addr_take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    wdc_wr    = state_ff.wr_pend & (state_ff.wr_addr == `WDB_WDC_ADDR);
    pgc_wr    = state_ff.wr_pend & (state_ff.wr_addr == `WDB_PGC_ADDR);
    // counting gated by run and idle mode
    counting  = state_ff.run & (~cpu_idle_i | state_ff.idle_run);
    div_wrap  = counting & (state_ff.div == 4'(CLK_DIV - 1));
    // mask of 2^(ps+1)-1 picks the prescale factor
    // shift count is four bits wide so that code 7 reaches 256
    pre_mask  = ({{(PRE_W-1){1'b0}}, 1'b1} << ({1'b0, state_ff.ps} + 4'h1)) - {{(PRE_W-1){1'b0}}, 1'b1};
    pre_tick  = div_wrap & ((state_ff.pre | ~pre_mask) == {PRE_W{1'b1}});
    ovf       = pre_tick & (state_ff.cnt == {CNT_W{1'b1}});
    // reset request lasts one cycle unless an event below raises it
    nxt_state.rst = 1'b0;

    // divider, prescaler and counter advance
    if (counting)
    begin
      // divider wraps every CLK_DIV counting clocks
      nxt_state.div = div_wrap ? 4'h0 : state_ff.div + 4'h1;
      // prescaler steps once per divider period
      if (div_wrap)
        nxt_state.pre = state_ff.pre + {{(PRE_W-1){1'b0}}, 1'b1};
      // counter steps once per prescaler period
      if (pre_tick)
        nxt_state.cnt = state_ff.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // bus write data phase to watchdog_control
    if (wdc_wr)
    begin
      // rising run bit starts from zero
      if (wd[`WDB_RUN_BIT] & ~state_ff.run)
      begin
        nxt_state.div = 4'h0;
        nxt_state.pre = '0;
        nxt_state.cnt = '0;
      end
      // restart bit is never stored, so it reads back cleared
      if (wd[`WDB_RESTART_BIT])
      begin
        nxt_state.div = 4'h0;
        nxt_state.pre = '0;
        nxt_state.cnt = '0;
      end
      nxt_state.run      = wd[`WDB_RUN_BIT];
      nxt_state.idle_run = wd[`WDB_IDLE_BIT];
      nxt_state.ps       = wd[`WDB_PS_LSB +: 3];
      // software may clear the flag but never set it
      nxt_state.wflag    = state_ff.wflag & wd[`WDB_FLAG_BIT];
    end

    // bus write data phase to programming_control
    if (pgc_wr)
    begin
      // enable bit and wait code are only stored here
      nxt_state.pg_en    = wd[`WDB_PGEN_BIT];
      nxt_state.boot_sel = wd[`WDB_BOOT_BIT];
      nxt_state.wt       = wd[`WDB_WT_LSB +: 3];
    end

    // reset events, highest priority; set beats any software clear
    // remember the pin level so that only its rising edge counts
    nxt_state.pin_d = pin_reset_i;
    // watchdog overflow: warm restart with the flag set
    if (ovf)
    begin
      nxt_state.rst      = 1'b1;
      nxt_state.cause    = wdb_pkg::WDB_CAUSE_WDOG;
      nxt_state.wflag    = 1'b1;
      nxt_state.boot_mon = 1'b0;
      nxt_state.boot_sel = 1'b0;
    end
    // rising pin level: warm restart, flag cleared
    else if (pin_reset_i & ~state_ff.pin_d)
    begin
      nxt_state.rst      = 1'b1;
      nxt_state.cause    = wdb_pkg::WDB_CAUSE_PIN;
      nxt_state.wflag    = 1'b0;
      nxt_state.boot_mon = 1'b0;
      nxt_state.boot_sel = 1'b0;
    end
    // software trigger: target follows the boot select bit
    else if (pgc_wr & wd[`WDB_SOFTWARE_RESET_TRIGGER_BIT])
    begin
      // trigger bit is never stored: cleared by hardware
      nxt_state.rst      = 1'b1;
      nxt_state.cause    = wdb_pkg::WDB_CAUSE_SOFT;
      nxt_state.wflag    = 1'b0;
      nxt_state.boot_mon = wd[`WDB_BOOT_BIT];
    end
    // every system reset stops the watchdog and zeroes its stages
    if (nxt_state.rst)
    begin
      nxt_state.run      = 1'b0;
      nxt_state.idle_run = 1'b0;
      nxt_state.ps       = 3'h0;
      nxt_state.div      = 4'h0;
      nxt_state.pre      = '0;
      nxt_state.cnt      = '0;
      nxt_state.pg_en    = 1'b0;
      nxt_state.wt       = 3'h0;
      nxt_state.ram_keep = 1'b1;
    end

    // address phase: latch writes, read from next values
    nxt_state.wr_pend = addr_take & ahb_i.hwrite;
    nxt_state.wr_addr = ahb_i.haddr[13:0];
    if (addr_take & ~ahb_i.hwrite)
    begin
      // watchdog_control image, restart bit reads 0
      if (ahb_i.haddr[13:0] == `WDB_WDC_ADDR)
        nxt_state.rdata = {24'h0, nxt_state.wflag, 1'b0, nxt_state.run, 1'b0,
                           nxt_state.idle_run, nxt_state.ps};
      // programming_control image, trigger bit reads 0
      else if (ahb_i.haddr[13:0] == `WDB_PGC_ADDR)
        nxt_state.rdata = {24'h0, nxt_state.pg_en, nxt_state.boot_sel, 3'h0,
                           nxt_state.wt};
      else
        nxt_state.rdata = 32'h0000_0000;    // unmapped reads zero
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // power-on leaves the flag clear and boots the monitor
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff          <= '0;
      state_ff.boot_sel <= `WDB_BOOT_RST;
      state_ff.boot_mon <= `WDB_BOOT_RST;
      state_ff.cause    <= wdb_pkg::WDB_CAUSE_POWER;
      state_ff.pin_d    <= 1'b1;
    end
    else
    begin
      // all state moves together on each edge
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero wait states, always okay
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp     = 1'b0;
  assign ahb_o.hrdata    = state_ff.rdata;
  // reset request, boot target and retention come straight from flops
  assign sys_reset_o     = state_ff.rst;
  assign boot_monitor_o  = state_ff.boot_mon;
  assign ram_retain_o    = state_ff.ram_keep;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // overflow raises the system reset on the next edge
  chk_ovf_reset: assert property (ovf |=> sys_reset_o)
    else $error("overflow without system reset");
  // a halted counter only moves through a write or a reset
  chk_halt_stable: assert property (!state_ff.run |=> $stable(state_ff.cnt) || sys_reset_o || $past(wdc_wr))
    else $error("counter moved while halted");
  // restart empties both stages on its effect edge
  chk_restart_zero: assert property (wdc_wr && wd[`WDB_RESTART_BIT]
                                     |=> state_ff.cnt == '0 && state_ff.pre == '0)
    else $error("restart did not zero stages");
  // idle without idle-run freezes divider and prescaler
  chk_idle_hold: assert property (state_ff.run && cpu_idle_i && !state_ff.idle_run && !wdc_wr && !pgc_wr
                                  && !nxt_state.rst |=> $stable(state_ff.pre) && $stable(state_ff.div))
    else $error("counting in idle without idle-run");
  // each prescaler period adds one to the counter
  chk_tick_count: assert property (pre_tick && !wdc_wr && !nxt_state.rst
                                   |=> state_ff.cnt == $past(state_ff.cnt) + 1'b1)
    else $error("counter missed a prescaler tick");
  // watchdog reset leaves the flag set and boots the application
  chk_flag_app: assert property (ovf |=> state_ff.wflag && !boot_monitor_o && ram_retain_o)
    else $error("watchdog reset flag or target wrong");
  // trigger with boot select set restarts in the monitor
  chk_soft_monitor: assert property (pgc_wr && wd == 8'h60 && !ovf && !(pin_reset_i && !state_ff.pin_d)
                                     |=> sys_reset_o && boot_monitor_o)
    else $error("monitor reset not taken");
  // trigger with boot select clear restarts in the application
  chk_soft_app: assert property (pgc_wr && wd == 8'h20 && !ovf |=> sys_reset_o && !boot_monitor_o)
    else $error("application reset not taken");
  // enabling a stopped watchdog starts from an empty counter
  chk_enable_zero: assert property (wdc_wr && wd[`WDB_RUN_BIT] && !state_ff.run && !nxt_state.rst
                                    |=> state_ff.run && state_ff.cnt == '0)
    else $error("enable did not start from zero");
  // a read of programming_control never shows the trigger bit
  chk_software_reset_trigger_clear: assert property (addr_take && !ahb_i.hwrite && ahb_i.haddr[13:0] == `WDB_PGC_ADDR
                                    |=> !ahb_o.hrdata[`WDB_SOFTWARE_RESET_TRIGGER_BIT])
    else $error("trigger bit read back set");
  // pin event restarts the application with the flag clear
  chk_pin_app: assert property (pin_reset_i && !state_ff.pin_d && !ovf
                                |=> sys_reset_o && !boot_monitor_o && !state_ff.wflag)
    else $error("pin reset target or flag wrong");
  // every warm reset keeps data ram
  chk_retain_warm: assert property (sys_reset_o |-> ram_retain_o)
    else $error("warm reset without ram retention");
  // every reset leaves the watchdog stopped with empty stages
  chk_reset_stop: assert property (sys_reset_o
                                   |-> !state_ff.run && state_ff.cnt == '0 && state_ff.pre == '0)
    else $error("reset left the watchdog running");
  // the divider restarts its period after each wrap
  chk_div_wrap: assert property (div_wrap && !wdc_wr && !nxt_state.rst |=> state_ff.div == 4'h0)
    else $error("divider did not wrap");
  // the flag stays set until software or another reset clears it
  chk_flag_hold: assert property (state_ff.wflag && !wdc_wr && !nxt_state.rst
                                  |=> state_ff.wflag)
    else $error("watchdog reset flag lost");

  // main scenarios: watchdog, software and pin reset, counting in idle, restart while running
  cov_wdog_reset: cover property (ovf ##1 sys_reset_o);
  cov_soft_reset: cover property (pgc_wr && wd[`WDB_SOFTWARE_RESET_TRIGGER_BIT]);
  cov_pin_reset: cover property (pin_reset_i && !state_ff.pin_d);
  cov_idle_count: cover property (counting && cpu_idle_i);
  cov_restart_run: cover property (wdc_wr && wd[`WDB_RESTART_BIT] && state_ff.run);

endmodule

// *** verification/wdb_top_test.sv ***
`timescale 1ns/1ps
`include "wdb_consts.svh"
module wdb_top_test;
  // ------------------------------------------------------------
  // shortened counts, addresses and bench signals
  // ------------------------------------------------------------
  localparam int          DIV = 2;                           // clocks per prescaler step
  localparam int          CW  = 3;                           // short counting stage
  localparam int          N0  = DIV * 2 * (1 << CW);         // overflow span at code 0
  localparam int          NP  = N0 + 1;                      // pulse is seen the cycle after overflow
  localparam logic [31:0] WDC = {18'h0, `WDB_WDC_ADDR};      // watchdog_control
  localparam logic [31:0] PGC = {18'h0, `WDB_PGC_ADDR};      // programming_control
  logic                   clk;                               // system clock
  logic                   rst_n;                             // power-on reset, active low
  logic                   sel;                               // slave select
  logic                   wr;                                // write transfer
  logic [1:0]             trans;                             // transfer kind
  logic [31:0]            addr;                              // byte address
  logic [31:0]            wdata;                             // write data
  logic                   idle;                              // core idle mode
  logic                   pin;                               // reset pin
  logic [31:0]            r;                                 // last read data
  int                     n;                                 // cycles waited
  int                     fail_count;                        // mismatches
  int                     check_count;                       // comparisons
  wdb_pkg::wdb_ahb_req_t  req;                               // bus request
  wdb_pkg::wdb_ahb_rsp_t  rsp;                               // bus answer
  logic                   sys_rst;                           // system reset pulse
  logic                   boot_mon;                          // restart target
  logic                   retain;                            // warm reset seen
  // the single slave's hreadyout is the bus hready
  assign req = '{hsel: sel, haddr: addr, htrans: trans, hwrite: wr, hsize: 3'h2,
                 hready: rsp.hreadyout, hwdata: wdata};
  // clock of 100 ns period
  always #50 clk = ~clk;
  // device under test with short counts
  wdb_top #(.CLK_DIV(DIV), .PRE_W(8), .CNT_W(CW)) u_wdb_top
  (
    .core_clk_i     (clk),
    .reset_n_i      (rst_n),
    .ahb_i          (req),
    .cpu_idle_i     (idle),
    .pin_reset_i    (pin),
    .ahb_o          (rsp),
    .sys_reset_o    (sys_rst),
    .boot_monitor_o (boot_mon),
    .ram_retain_o   (retain)
  );
  // ------------------------------------------------------------
  // helper tasks
  // ------------------------------------------------------------
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  // one single ahb-lite transfer; returns at the data phase edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    sel   <= 1'b1;
    trans <= `WDB_HTRANS_NSEQ;
    wr    <= w;
    addr  <= a;
    @(posedge clk);
    // address phase held until hready is seen high
    while (rsp.hreadyout !== 1'b1)
    begin
      @(posedge clk);
    end
    sel   <= 1'b0;
    trans <= 2'h0;
    wdata <= d;
    @(posedge clk);
    // data phase held until hready is seen high
    while (rsp.hreadyout !== 1'b1)
    begin
      @(posedge clk);
    end
    r = rsp.hrdata;
    // the slave always answers okay
    check(rsp.hresp, 32'h0);
  endtask
  // count settled cycles until the reset pulse or the limit
  task wait_pulse(input int max);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (sys_rst !== 1'b1 && n < max);
  endtask
  // pulse after exactly exp_n cycles, one cycle wide
  task expect_reset(input int exp_n);
    wait_pulse(exp_n + 8);
    check(n, exp_n);
    @(negedge clk);
    check(sys_rst, 32'h0);
  endtask
  // verdict and end of run
  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // hang guard, far beyond the expected run
  // ------------------------------------------------------------
  initial
  begin
    #(100 * 60000);
    fail_count++;
    end_sim();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    {clk, rst_n, sel, wr, trans, addr, wdata, idle, pin} = '0;
    fail_count  = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // power-on state, register fields, unmapped place
    bus(1'b0, WDC, 32'h0);
    check(r, 32'h0);
    check(boot_mon, 32'h1);
    check(retain, 32'h0);
    bus(1'b1, WDC, 32'h0000_001B);
    bus(1'b0, WDC, 32'h0);
    check(r, 32'h0000_000B);
    bus(1'b1, 32'h0000_0100, 32'h0000_00FF);
    bus(1'b0, 32'h0000_0100, 32'h0);
    check(r, 32'h0);
    bus(1'b1, PGC, 32'h0000_00C7);
    bus(1'b0, PGC, 32'h0);
    check(r, 32'h0000_00C7);
    $display("test registers done");
    // every prescale code: overflow span and warm reset effects
    for (int p = 0; p < 8; p++)
    begin
      bus(1'b1, WDC, 32'h0000_0020 | 32'(p));
      expect_reset(DIV * (2 << p) * (1 << CW) + 1);
      bus(1'b0, WDC, 32'h0);
      check(r, 32'h0000_0080);
      check(boot_mon, 32'h0);
      check(retain, 32'h1);
      bus(1'b1, WDC, 32'h0);
    end
    $display("test prescale done");
    // restart in mid-count recounts from zero
    bus(1'b1, WDC, 32'h0000_0020);
    repeat (20) @(posedge clk);
    bus(1'b1, WDC, 32'h0000_0030);
    expect_reset(NP);
    // clearing run halts the count
    bus(1'b1, WDC, 32'h0000_0020);
    repeat (10) @(posedge clk);
    bus(1'b1, WDC, 32'h0);
    wait_pulse(2 * N0);
    check(n, 2 * N0);
    $display("test restart and halt done");
    // idle mode with and without idle-run
    @(posedge clk);
    idle <= 1'b1;
    bus(1'b1, WDC, 32'h0000_0028);
    expect_reset(NP);
    bus(1'b1, WDC, 32'h0000_0020);
    wait_pulse(2 * N0);
    check(n, 2 * N0);
    @(posedge clk);
    idle <= 1'b0;
    expect_reset(NP);
    $display("test idle done");
    // software resets into each boot target
    bus(1'b1, PGC, 32'h0000_0060);
    expect_reset(1);
    check(boot_mon, 32'h1);
    bus(1'b0, PGC, 32'h0);
    check(r, 32'h0000_0040);
    bus(1'b1, PGC, 32'h0000_0020);
    expect_reset(1);
    check(boot_mon, 32'h0);
    // pin reset returns to the application area
    bus(1'b1, PGC, 32'h0000_0060);
    expect_reset(1);
    @(posedge clk);
    pin <= 1'b1;
    expect_reset(2);
    check(boot_mon, 32'h0);
    @(posedge clk);
    pin <= 1'b0;
    $display("test boot targets done");
    // power-on after a watchdog reset, with the watchdog stopped, is a cold start
    bus(1'b1, WDC, 32'h0000_0020);
    expect_reset(NP);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, WDC, 32'h0);
    check(r, 32'h0);
    check(boot_mon, 32'h1);
    check(retain, 32'h0);
    $display("test cold start done");
    end_sim();
  end
endmodule
